/* File: src/sacsc_serial_control.sv */
// Purpose: serial control byte decode and conversion sequencing
// Assumes: sar_compare settles within one serial clock of the trial code
// Notes: link logic runs on serial_clock, cleared while chip_select_n is high except the captured result word and the width pin synchroniser
`default_nettype none
module sacsc_serial_control #(
   parameter int unsigned RES_W = sacsc_pkg::RES_W
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             serial_clock,
   input  wire logic             chip_select_n,
   input  wire logic             serial_data_in,
   output logic                  serial_data_out,
   output logic                  serial_data_out_oe,
   input  wire logic             resolution_enable_pin,
   input  wire logic             sar_compare,
   output logic      [RES_W-1:0] sar_trial_code,
   output logic      [3:0]       positive_input_sel,
   output logic      [3:0]       negative_input_sel,
   output logic                  shared_negative_ref_sel,
   output logic                  sample_enable,
   output logic                  hold_enable,
   output logic                  power_down,
   output logic      [RES_W-1:0] result_word,
   output logic                  result_is_8bit,
   output logic                  result_valid
);
   localparam logic [3:0] MSB_POS = 4'(RES_W - 1);
   localparam int unsigned PAD_W  = RES_W - sacsc_pkg::SHORT_W;

   sacsc_pkg::sacsc_rx_t rx_state_reg;
   sacsc_pkg::sacsc_cv_t cv_state_reg;
   logic [3:0]       rx_cnt_reg;
   logic [6:0]       shift_reg;
   logic [2:0]       chan_reg;
   logic             single_reg;
   logic             sample_reg;
   logic [3:0]       cv_cnt_reg;
   logic             width8_reg;
   logic [1:0]       pd_reg;
   logic [RES_W-1:0] trial_reg;
   logic             out_bit_reg;
   logic             ready_reg;
   logic             pdown_reg;
   logic             dout_reg;
   logic [RES_W-1:0] link_result_reg;
   logic             link_w8_reg;
   logic             ready_seen_reg;
   logic [RES_W-1:0] result_reg;
   logic             result_w8_reg;
   logic             valid_reg;

   logic             res_en_s;
   logic             ready_s;
   logic [7:0]       ctrl_byte;
   logic [3:0]       width_now;
   logic [3:0]       bit_pos;
   logic             cv_active;
   logic             start_ok;
   logic             start_seen;
   logic             byte_done;
   logic             last_dec;
   logic [RES_W-1:0] trial_next;

   // width pin is static; select clears it only on serial clock edges that run while select is high
   sacsc_sync #(
      .WIDTH (1)
   ) u_res_sync (
      .clk (serial_clock),
      .rst (chip_select_n),
      .d   (resolution_enable_pin),
      .q   (res_en_s)
   );

   assign ctrl_byte = {shift_reg, serial_data_in};
   assign width_now = width8_reg ? sacsc_pkg::LEN_SHORT : sacsc_pkg::LEN_FULL;
   assign bit_pos   = 4'(MSB_POS - cv_cnt_reg);
   assign cv_active = (cv_state_reg == sacsc_pkg::CV_CONV);
   assign last_dec  = cv_active && (cv_cnt_reg == 4'(width_now - 4'h1));
   // a new byte may overlap the tail of the running conversion
   assign start_ok  = !cv_active ||
                      (cv_cnt_reg >= 4'(width_now - sacsc_pkg::ACQ_LEAD));
   assign start_seen = (rx_state_reg == sacsc_pkg::RX_IDLE) &&
                       serial_data_in && start_ok;
   assign byte_done  = (rx_state_reg == sacsc_pkg::RX_CTRL) &&
                       (rx_cnt_reg == sacsc_pkg::CNT_LAST);

   sacsc_sar_step #(
      .WIDTH (RES_W),
      .POS_W (4)
   ) u_sar (
      .trial      (trial_reg),
      .bit_pos    (bit_pos),
      .keep       (sar_compare),
      .last       (last_dec),
      .next_trial (trial_next)
   );

   // control byte receiver, msb first
   always_ff @(posedge serial_clock or posedge chip_select_n) begin
      if (chip_select_n) begin
         rx_state_reg <= sacsc_pkg::RX_IDLE;
         rx_cnt_reg   <= 4'h0;
         shift_reg    <= 7'h00;
      end else begin
         case (rx_state_reg)
            sacsc_pkg::RX_IDLE: begin
               if (start_seen) begin
                  rx_state_reg <= sacsc_pkg::RX_CTRL;
                  rx_cnt_reg   <= 4'h1;
                  shift_reg    <= 7'h01;
               end
            end
            default: begin
               shift_reg  <= ctrl_byte[6:0];
               rx_cnt_reg <= rx_cnt_reg + 4'h1;
               if (byte_done) begin
                  rx_state_reg <= sacsc_pkg::RX_IDLE;
                  rx_cnt_reg   <= 4'h0;
               end
            end
         endcase
      end
   end

   // multiplexer set as soon as channel and mode bits are in
   always_ff @(posedge serial_clock or posedge chip_select_n) begin
      if (chip_select_n) begin
         chan_reg   <= 3'h0;
         single_reg <= 1'b0;
      end else if (rx_state_reg == sacsc_pkg::RX_CTRL) begin
         if (rx_cnt_reg == sacsc_pkg::CNT_CHAN) begin
            chan_reg <= {shift_reg[1:0], serial_data_in};
         end
         if (rx_cnt_reg == sacsc_pkg::CNT_SGL) begin
            single_reg <= serial_data_in;
         end
      end
   end

   // sampling window: from the fifth control bit until the byte is whole
   always_ff @(posedge serial_clock or posedge chip_select_n) begin
      if (chip_select_n) begin
         sample_reg <= 1'b0;
      end else if (byte_done) begin
         sample_reg <= 1'b0;
      end else if (rx_state_reg == sacsc_pkg::RX_CTRL &&
                   rx_cnt_reg == sacsc_pkg::CNT_ACQ) begin
         sample_reg <= 1'b1;
      end
   end

   // conversion sequencer; decision per rising edge while in hold
   always_ff @(posedge serial_clock or posedge chip_select_n) begin
      if (chip_select_n) begin
         cv_state_reg <= sacsc_pkg::CV_IDLE;
         cv_cnt_reg   <= 4'h0;
         width8_reg   <= 1'b0;
         pd_reg       <= sacsc_pkg::PD_AUTO;
         trial_reg    <= '0;
         out_bit_reg  <= 1'b0;
         ready_reg    <= 1'b0;
      end else begin
         case (cv_state_reg)
            sacsc_pkg::CV_IDLE: begin
               out_bit_reg <= 1'b0;
            end
            default: begin
               trial_reg   <= trial_next;
               out_bit_reg <= sar_compare;
               cv_cnt_reg  <= cv_cnt_reg + 4'h1;
               if (last_dec) begin
                  cv_state_reg <= sacsc_pkg::CV_IDLE;
                  ready_reg    <= 1'b1;
               end
            end
         endcase
         if (byte_done) begin
            cv_state_reg <= sacsc_pkg::CV_CONV;
            cv_cnt_reg   <= 4'h0;
            trial_reg    <= {1'b1, {(RES_W-1){1'b0}}};
            width8_reg   <= res_en_s & ctrl_byte[sacsc_pkg::MODE_POS];
            pd_reg       <= ctrl_byte[sacsc_pkg::PD_MSB:sacsc_pkg::PD_LSB];
            out_bit_reg  <= 1'b0;
            ready_reg    <= 1'b0;
         end
      end
   end

   // reserved power codes are treated as full power
   always_ff @(posedge serial_clock or posedge chip_select_n) begin
      if (chip_select_n) begin
         pdown_reg <= 1'b1;
      end else if (start_seen) begin
         pdown_reg <= 1'b0;
      end else if (last_dec && rx_state_reg == sacsc_pkg::RX_IDLE) begin
         pdown_reg <= (pd_reg == sacsc_pkg::PD_AUTO);
      end
   end

   // result word for the system side; stays put until the next conversion ends
   always_ff @(posedge serial_clock) begin
      if (last_dec) begin
         link_result_reg <= width8_reg ?
            {{PAD_W{1'b0}}, trial_next[RES_W-1 -: sacsc_pkg::SHORT_W]} : trial_next;
         link_w8_reg     <= width8_reg;
      end
   end

   // output changes after the falling edge, ready for the host's rising edge
   always_ff @(negedge serial_clock or posedge chip_select_n) begin
      if (chip_select_n) begin
         dout_reg <= 1'b0;
      end else begin
         dout_reg <= out_bit_reg;
      end
   end

   // ready is high for at least three serial clocks, far longer than the sync
   sacsc_sync #(
      .WIDTH (1)
   ) u_ready_sync (
      .clk (mclk),
      .rst (rst),
      .d   (ready_reg),
      .q   (ready_s)
   );

   always_ff @(posedge mclk) begin
      if (rst) begin
         ready_seen_reg <= 1'b0;
         valid_reg      <= 1'b0;
      end else begin
         ready_seen_reg <= ready_s;
         valid_reg      <= ready_s && !ready_seen_reg;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         result_reg    <= '0;
         result_w8_reg <= 1'b0;
      end else if (ready_s && !ready_seen_reg) begin
         result_reg    <= link_result_reg;
         result_w8_reg <= link_w8_reg;
      end
   end

   assign serial_data_out         = dout_reg;
   assign serial_data_out_oe      = !chip_select_n;
   assign sar_trial_code          = trial_reg;
   assign positive_input_sel      = sacsc_pkg::sacsc_pos_sel(chan_reg);
   assign negative_input_sel      = sacsc_pkg::sacsc_neg_sel(chan_reg, single_reg);
   assign shared_negative_ref_sel = single_reg;
   assign sample_enable           = sample_reg;
   assign hold_enable             = cv_active;
   assign power_down              = pdown_reg;
   assign result_word             = result_reg;
   assign result_is_8bit          = result_w8_reg;
   assign result_valid            = valid_reg;

   property p_single_route;
      @(posedge serial_clock) disable iff (chip_select_n)
      (single_reg && chan_reg == 3'h5) |->
         positive_input_sel == 4'h2 && negative_input_sel == 4'h0 &&
         shared_negative_ref_sel;
   endproperty
   a_single_route: assert property (p_single_route)
      else $error("single-ended code 101 not routed to input 1");

   property p_diff_route;
      @(posedge serial_clock) disable iff (chip_select_n)
      (!single_reg && chan_reg == 3'h6) |->
         positive_input_sel == 4'h8 && negative_input_sel == 4'h4 &&
         !shared_negative_ref_sel;
   endproperty
   a_diff_route: assert property (p_diff_route)
      else $error("differential code 110 not routed to 3/2");

   property p_acq_window;
      @(posedge serial_clock) disable iff (chip_select_n)
      (rx_state_reg == sacsc_pkg::RX_CTRL && rx_cnt_reg == 4'h4) |=>
         sample_enable ##1 sample_enable ##1 sample_enable ##1 !sample_enable;
   endproperty
   a_acq_window: assert property (p_acq_window)
      else $error("acquisition window is not three clocks");

   property p_hold_after_byte;
      @(posedge serial_clock) disable iff (chip_select_n)
      byte_done |=> hold_enable && !sample_enable;
   endproperty
   a_hold_after_byte: assert property (p_hold_after_byte)
      else $error("hold not entered after the control byte");

   property p_conv_span;
      @(posedge serial_clock) disable iff (chip_select_n)
      ($rose(hold_enable) && !width8_reg) |-> ##11 hold_enable ##1 !hold_enable;
   endproperty
   a_conv_span: assert property (p_conv_span)
      else $error("12-bit conversion not twelve clocks");

   property p_conv_span8;
      @(posedge serial_clock) disable iff (chip_select_n)
      ($rose(hold_enable) && width8_reg) |-> ##7 hold_enable ##1 !hold_enable;
   endproperty
   a_conv_span8: assert property (p_conv_span8)
      else $error("8-bit conversion not eight clocks");

   property p_tail_low;
      @(posedge serial_clock) disable iff (chip_select_n)
      $fell(hold_enable) |=> !serial_data_out [*3];
   endproperty
   a_tail_low: assert property (p_tail_low)
      else $error("output not low after the last result bit");

   property p_din_ignored;
      @(posedge serial_clock) disable iff (chip_select_n)
      (rx_state_reg == sacsc_pkg::RX_IDLE && !serial_data_in) |=>
         rx_state_reg == sacsc_pkg::RX_IDLE;
   endproperty
   a_din_ignored: assert property (p_din_ignored)
      else $error("receiver left idle without a start bit");

   property p_res_pin_low;
      @(posedge serial_clock) disable iff (chip_select_n)
      (byte_done && !res_en_s) |=> !width8_reg;
   endproperty
   a_res_pin_low: assert property (p_res_pin_low)
      else $error("8-bit width chosen with the width pin low");

   property p_auto_down;
      @(posedge serial_clock) disable iff (chip_select_n)
      (last_dec && pd_reg == 2'h0 && !start_seen &&
       rx_state_reg == sacsc_pkg::RX_IDLE) |=> power_down;
   endproperty
   a_auto_down: assert property (p_auto_down)
      else $error("no power-down after conversion in mode 00");

   property p_wake;
      @(posedge serial_clock) disable iff (chip_select_n)
      start_seen |=> !power_down [*8] ##1 hold_enable;
   endproperty
   a_wake: assert property (p_wake)
      else $error("not powered through a control byte");

   property p_full_power;
      @(posedge serial_clock) disable iff (chip_select_n)
      (pd_reg == 2'h3 && !cv_active) |-> !power_down;
   endproperty
   a_full_power: assert property (p_full_power)
      else $error("powered down in mode 11");

   property p_msb_first;
      @(posedge serial_clock) disable iff (chip_select_n)
      $rose(hold_enable) |-> sar_trial_code == 12'h800 ##1
         serial_data_out == $past(sar_compare);
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("first result bit is not the msb decision");

   property p_short_format;
      @(posedge mclk) disable iff (rst)
      (result_valid && result_is_8bit) |-> result_word[11:8] == 4'h0;
   endproperty
   a_short_format: assert property (p_short_format)
      else $error("8-bit result not right aligned");
endmodule // sacsc_serial_control
`default_nettype wire

/* File: src/sacsc_pkg.sv */
// Purpose: constants, types and decode helpers of the serial converter control
// Assumes: control byte arrives most significant bit first
// Notes:
`default_nettype none
package sacsc_pkg;
   localparam int unsigned RES_W    = 12;
   localparam int unsigned SHORT_W  = 8;
   localparam int unsigned CTRL_W   = 8;
   localparam int unsigned ACQ_CLKS = 3;
   localparam int unsigned MODE_POS = 3;
   localparam int unsigned PD_MSB   = 1;
   localparam int unsigned PD_LSB   = 0;
   // bits received before acquisition starts; also the overlap lead
   localparam logic [3:0] ACQ_LEAD  = 4'(CTRL_W - ACQ_CLKS);
   localparam logic [3:0] CNT_CHAN  = 4'h3;
   localparam logic [3:0] CNT_ACQ   = 4'(ACQ_LEAD - 4'h1);
   localparam logic [3:0] CNT_SGL   = 4'h5;
   localparam logic [3:0] CNT_LAST  = 4'(CTRL_W - 1);
   localparam logic [3:0] LEN_FULL  = 4'(RES_W);
   localparam logic [3:0] LEN_SHORT = 4'(SHORT_W);
   localparam logic [1:0] PD_AUTO   = 2'h0;
   localparam logic [1:0] PD_FULL   = 2'h3;
   localparam logic [2:0] CODE_IN0  = 3'h1;
   localparam logic [2:0] CODE_IN1  = 3'h5;
   localparam logic [2:0] CODE_IN2  = 3'h2;
   localparam logic [2:0] CODE_IN3  = 3'h6;

   typedef enum logic {RX_IDLE, RX_CTRL} sacsc_rx_t;
   typedef enum logic {CV_IDLE, CV_CONV} sacsc_cv_t;

   function automatic logic [3:0] sacsc_pos_sel(input logic [2:0] code);
      if (code == CODE_IN0) return 4'h1;
      else if (code == CODE_IN1) return 4'h2;
      else if (code == CODE_IN2) return 4'h4;
      else if (code == CODE_IN3) return 4'h8;
      else return 4'h0;
   endfunction

   // differential partner is the other input of the same pair
   function automatic logic [3:0] sacsc_neg_sel(input logic [2:0] code,
                                                input logic       single);
      logic [3:0] p;
      p = sacsc_pos_sel(code);
      return single ? 4'h0 : {p[2], p[3], p[0], p[1]};
   endfunction
endpackage
`default_nettype wire

/* File: src/sacsc_sync.sv */
// Purpose: two flip-flop synchroniser for levels
// Assumes: input is a slow level relative to clk
// Notes: first stage is read only by the second
`default_nettype none
module sacsc_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= d;
         sync_reg <= meta_reg;
      end
   end

   assign q = sync_reg;
endmodule // sacsc_sync
`default_nettype wire

/* File: src/sacsc_sar_step.sv */
// Purpose: one successive approximation decision on the trial code
// Assumes: keep is high when the held input is at or above the trial
// Notes: combinational; the caller holds the trial in a register
`default_nettype none
module sacsc_sar_step #(
   parameter int unsigned WIDTH = 12,
   parameter int unsigned POS_W = 4
) (
   input  wire logic [WIDTH-1:0] trial,
   input  wire logic [POS_W-1:0] bit_pos,
   input  wire logic             keep,
   input  wire logic             last,
   output logic      [WIDTH-1:0] next_trial
);
   always_comb begin
      next_trial = trial;
      next_trial[bit_pos] = keep;
      // no trial bit below the last decision, so the code stays exact
      if (!last && bit_pos != '0) begin
         next_trial[bit_pos - POS_W'(1)] = 1'b1;
      end
   end
endmodule // sacsc_sar_step
`default_nettype wire

/* File: bench/sacsc_host.sv */
// Purpose: host serial master that frames one conversion on the converter link
// Assumes: link clock idles low and runs only inside a frame
// Notes: the input line shows the inverse of its last bit once released
`default_nettype none
module sacsc_host (
   output logic        serial_clock,
   output logic        chip_select_n,
   output logic        serial_data_in,
   input  wire logic   serial_data_out,
   output int          rise_n,
   output logic [23:0] rx
);
   timeunit 1ns;
   timeprecision 100ps;

   // select starts low and rises later, so the link logic sees a real clearing edge
   initial begin
      serial_clock   = 1'b0;
      chip_select_n  = 1'b0;
      serial_data_in = 1'b0;
      rise_n         = 0;
      rx             = 24'h0;
      #10;
      chip_select_n  = 1'b1;
   end

   // lead clocks carry zeros before the start bit; odd select setup keeps phase loose
   // junk bits land on the first conversion clocks; any ones among them come before a new start is allowed
   task automatic frame(input logic [7:0] ctrl, input logic [6:0] junk, input int lead);
      logic [23:0] bits;
      bits = {ctrl, junk, 9'h000};
      chip_select_n = 1'b0;
      #103.7;
      for (int i = 0; i < lead + 24; i++) begin
         serial_data_in = (i < lead) ? 1'b0 : bits[23 - (i - lead)];
         #62.5;
         serial_clock = 1'b1;
         if (i >= lead) begin
            rise_n = i - lead + 1;
            rx     = {rx[22:0], serial_data_out};
         end
         #62.5;
         serial_clock = 1'b0;
      end
      #62.5;
      chip_select_n  = 1'b1;
      rise_n         = 0;
      serial_data_in = ~serial_data_in;
   endtask
endmodule // sacsc_host
`default_nettype wire

/* File: bench/test_sacsc_serial_control.sv */
// Purpose: self-checking bench of the serial converter control
// Assumes: comparator modelled as held input at or above the trial code
// Notes: 8-bit results expected as the top eight bits of the held input
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fails++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module test_sacsc_serial_control;
   timeunit 1ns;
   timeprecision 100ps;

   logic        mclk;
   logic        rst;
   logic        res_pin;
   logic [11:0] ana;
   logic [3:0]  exp_pos;
   logic [3:0]  exp_neg;
   logic        exp_sgl;
   logic        exp8;
   logic        exp_pd;
   int          fails = 0;
   int          tests_run = 0;
   int          cycles = 0;
   int          nvalid = 0;
   int          rise_n;
   wire logic        serial_clock;
   wire logic        chip_select_n;
   wire logic        serial_data_in;
   wire logic        serial_data_out;
   wire logic        serial_data_out_oe;
   wire logic        sar_compare;
   wire logic [11:0] sar_trial_code;
   wire logic [3:0]  positive_input_sel;
   wire logic [3:0]  negative_input_sel;
   wire logic        shared_negative_ref_sel;
   wire logic        sample_enable;
   wire logic        hold_enable;
   wire logic        power_down;
   wire logic [11:0] result_word;
   wire logic        result_is_8bit;
   wire logic        result_valid;
   wire logic [23:0] rx;

   assign sar_compare = (ana >= sar_trial_code);

   sacsc_serial_control uut (
      .mclk                    (mclk),
      .rst                     (rst),
      .serial_clock            (serial_clock),
      .chip_select_n           (chip_select_n),
      .serial_data_in          (serial_data_in),
      .serial_data_out         (serial_data_out),
      .serial_data_out_oe      (serial_data_out_oe),
      .resolution_enable_pin   (res_pin),
      .sar_compare             (sar_compare),
      .sar_trial_code          (sar_trial_code),
      .positive_input_sel      (positive_input_sel),
      .negative_input_sel      (negative_input_sel),
      .shared_negative_ref_sel (shared_negative_ref_sel),
      .sample_enable           (sample_enable),
      .hold_enable             (hold_enable),
      .power_down              (power_down),
      .result_word             (result_word),
      .result_is_8bit          (result_is_8bit),
      .result_valid            (result_valid)
   );

   sacsc_host host (
      .serial_clock    (serial_clock),
      .chip_select_n   (chip_select_n),
      .serial_data_in  (serial_data_in),
      .serial_data_out (serial_data_out),
      .rise_n          (rise_n),
      .rx              (rx)
   );

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic end_sim;
      if (fails == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // a hang in the link shows up as the cycle ceiling being reached
   // counted away from the launching edge so the pulse is read where it has settled
   always @(negedge mclk) begin
      if (result_valid === 1'b1) nvalid++;
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 6000) begin
         fails++;
         end_sim;
      end
   end

   // mid-frame views, taken a little after the rising link edge has landed
   always @(posedge serial_clock) begin
      #5;
      `CHK("oe", ~chip_select_n, serial_data_out_oe)
      if (rise_n == 6) `CHK("sample", 1'b1, sample_enable)
      if (rise_n == 9) begin
         `CHK("acq end", 1'b0, sample_enable)
         `CHK("hold", 1'b1, hold_enable)
         `CHK("pos sel", exp_pos, positive_input_sel)
         `CHK("neg sel", exp_neg, negative_input_sel)
         `CHK("com sel", exp_sgl, shared_negative_ref_sel)
         `CHK("awake", 1'b0, power_down)
      end
      if (rise_n == 17) `CHK("hold len", ~exp8, hold_enable)
      if (rise_n == 22) begin
         `CHK("hold off", 1'b0, hold_enable)
         `CHK("power", exp_pd, power_down)
      end
   end

   task automatic run(input int i, input logic sgl, input logic wbit, input logic [1:0] pd,
                      input logic pin, input logic [11:0] val, input int lead);
      logic [2:0]  codes [4];
      logic [11:0] want;
      logic [11:0] got;
      int          n0;
      codes = '{3'h1, 3'h5, 3'h2, 3'h6};
      @(posedge mclk);
      #1;
      ana     = val;
      res_pin = pin;
      exp8    = pin & wbit;
      exp_pd  = (pd == 2'h0);
      exp_sgl = sgl;
      exp_pos = 4'h1 << i;
      exp_neg = sgl ? 4'h0 : 4'h1 << (i ^ 1);
      want    = exp8 ? {4'h0, val[11:4]} : val;
      n0      = nvalid;
      host.frame({1'b1, codes[i], wbit, sgl, pd}, (exp8 ? 7'h50 : 7'h55), lead);
      got = exp8 ? {4'h0, rx[14:7]} : rx[14:3];
      `CHK("dout result", want, got)
      `CHK("dout tail", 7'h0, (exp8 ? rx[6:0] : {4'h0, rx[2:0]}))
      repeat (4) @(posedge mclk);
      #1;
      `CHK("result_word", want, result_word)
      `CHK("result_is_8bit", exp8, result_is_8bit)
      `CHK("result count", n0 + 1, nvalid)
      `CHK("idle oe", 1'b0, serial_data_out_oe)
      `CHK("idle power", 1'b1, power_down)
   endtask

   initial begin
      rst     = 1'b1;
      res_pin = 1'b0;
      ana     = 12'h0;
      repeat (4) @(posedge mclk);
      #1;
      rst = 1'b0;
      `CHK("reset word", 12'h0, result_word)
      for (int i = 0; i < 4; i++) begin
         for (int s = 0; s < 2; s++) begin
            run(i, s[0], 1'b0, (s ? 2'h0 : 2'h3), 1'b1, 12'(i * 1170 + s * 2047), i);
         end
      end
      run(0, 1'b1, 1'b1, 2'h3, 1'b0, 12'hfff, 0);
      run(3, 1'b0, 1'b1, 2'h0, 1'b1, 12'hab7, 2);
      run(1, 1'b0, 1'b1, 2'h3, 1'b1, 12'h000, 0);
      end_sim;
   end
endmodule // test_sacsc_serial_control
`default_nettype wire
